// >>> hw/bringup_seq_map.vh
// Constants for the board bring-up command sequencer
`ifndef BRINGUP_SEQ_MAP_VH
`define BRINGUP_SEQ_MAP_VH
// Adapter channels
`define CH_CTRL 8'h00
`define CH_PIN 8'h02
`define CH_I2C0 8'h03
`define CH_I2C1 8'h04
// Adapter commands
`define CMD_CRB_WR 8'h02
`define CMD_CRC_WR 8'h04
`define CMD_CRD_WR 8'h06
`define CMD_I2C_CTRL_WR 8'h30
`define CMD_DIR_WR 8'h20
`define CMD_PIN_OUT_WR 8'h10
`define CMD_PIN_OUT_RD 8'h11
`define CMD_PIN_IN_RD 8'h01
// Values written
`define VAL_CRB 32'h1c000000
`define VAL_CRC 32'h00000000
`define VAL_CRD 32'h10000000
`define VAL_I2C_CTRL 32'h88000000
`define VAL_DIR 32'h08400638
`define VAL_POWER 32'h08400200
`define VAL_CONFIG_REQ 32'h8c600238
`define VAL_RELEASE 32'h08400238
// Output bit positions
`define BIT_RAIL_HIGH 27
`define BIT_RAIL_LOW 22
`define BIT_FPGA_PWR 9
`define BIT_CFG_LEFT 3
`define BIT_CFG_MID 4
`define BIT_CFG_RIGHT 5
`define BIT_RST_LEFT 21
`define BIT_RST_MID 26
`define BIT_RST_RIGHT 31
// Flash layout, byte addresses
`define FLASH_GOLDEN_BASE 24'h000000
`define FLASH_APP_BASE 24'h800000
// Step count and reply timeout default
`define STEP_COUNT 9
`define TIMEOUT_DEFAULT 24'h00ffff
`endif

// >>> hw/step_rom.v
// Command table: channel, command and data for each bring-up step
`timescale 1ns/1ps
`include "bringup_seq_map.vh"

module step_rom (
    input wire [3:0] step_in,    // Step index
    output reg [7:0] chan_out,   // Adapter channel
    output reg [7:0] cmd_out,    // Adapter command
    output reg [31:0] data_out   // Data word, most significant byte first
);
    // Fixed order: control regs, I2C, direction, power, config, release
    always @* begin
        case (step_in)
            4'h0: begin chan_out = `CH_CTRL; cmd_out = `CMD_CRB_WR; data_out = `VAL_CRB; end
            4'h1: begin chan_out = `CH_CTRL; cmd_out = `CMD_CRC_WR; data_out = `VAL_CRC; end
            4'h2: begin chan_out = `CH_CTRL; cmd_out = `CMD_CRD_WR; data_out = `VAL_CRD; end
            4'h3: begin chan_out = `CH_I2C0; cmd_out = `CMD_I2C_CTRL_WR; data_out = `VAL_I2C_CTRL; end
            4'h4: begin chan_out = `CH_I2C1; cmd_out = `CMD_I2C_CTRL_WR; data_out = `VAL_I2C_CTRL; end
            4'h5: begin chan_out = `CH_PIN; cmd_out = `CMD_DIR_WR; data_out = `VAL_DIR; end
            4'h6: begin chan_out = `CH_PIN; cmd_out = `CMD_PIN_OUT_WR; data_out = `VAL_POWER; end
            4'h7: begin chan_out = `CH_PIN; cmd_out = `CMD_PIN_OUT_WR; data_out = `VAL_CONFIG_REQ; end
            default: begin chan_out = `CH_PIN; cmd_out = `CMD_PIN_OUT_WR; data_out = `VAL_RELEASE; end
        endcase
    end
endmodule

// >>> hw/board_bringup_command_sequencer.v
// Board bring-up sequencer issuing adapter commands over the external control field
//
// Behaviour
// - I2C value 0x88 means 100 kHz, two bytes, push-pull clock.
// - Every output write carries the full 32-bit value.
// - Read outputs 0x11, inputs 0x01 on 0x02; reply flag then four bytes.
// - Each FPGA loads its stored image when its configuration line activates.
// - Configuration lines of left, middle, right FPGAs are bits 3, 4, 5.
// - Soft resets of left, middle, right FPGAs are bits 21, 26, 31.
// - Golden image at byte 0, application image at byte 0x800000.
// - Flash image boundaries are byte addresses.
`timescale 1ns/1ps
`include "bringup_seq_map.vh"

module board_bringup_command_sequencer (
    input wire core_clk_in,            // 250 MHz clock
    input wire rst_in,                 // Synchronous reset, active high
    input wire start_in,               // Pulse: run full bring-up
    input wire reload_in,              // Pulse: rerun config request and release only
    input wire [23:0] timeout_in,      // Reply timeout in cycles, zero uses default
    input wire cmd_ready_in,           // Frame encoder accepts a command
    input wire reply_valid_in,         // Reply pulse from frame decoder
    input wire [7:0] reply_flag_in,    // Reply error flag byte
    input wire [23:0] flash_addr_in,   // Flash byte address of a proposed write
    input wire [23:0] flash_end_in,    // Application image end byte address
    output wire cmd_valid_out,         // Command waiting to be taken
    output reg [7:0] cmd_chan_out,     // Adapter channel of command
    output reg [7:0] cmd_code_out,     // Adapter command code
    output reg [31:0] cmd_data_out,    // Command data, full 32-bit word
    output reg [31:0] pin_shadow_out,  // Shadow of last written output word
    output wire busy_out,              // Sequence in progress
    output reg done_out,               // Sequence completed
    output reg error_out,              // Sequence stopped on error
    output reg timeout_err_out,        // Error was a timeout
    output reg [7:0] err_flag_out,     // Flag byte of failing reply
    output reg [3:0] err_step_out,     // Step that failed
    output wire flash_write_ok_out     // Address lies inside application window
);
    // ****************************************
    // State machine codes
    // ****************************************
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SEND = 4'b0010;
    localparam [3:0] S_WAIT = 4'b0100;
    localparam [3:0] S_STOP = 4'b1000;
    // Index of the last step; a good reply to it ends the run
    localparam integer LAST_STEP_INT = `STEP_COUNT - 1;
    localparam [3:0] LAST_STEP = LAST_STEP_INT[3:0];

    // ****************************************
    // State, step and table outputs
    // ****************************************
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [3:0] step_r;
    reg [3:0] step_nxt;
    reg [23:0] wait_cnt_r;
    wire [7:0] rom_chan;
    wire [7:0] rom_cmd;
    wire [31:0] rom_data;
    wire [23:0] limit;

    // ****************************************
    // Command table
    // ****************************************
    step_rom u_rom (
        .step_in(step_nxt),
        .chan_out(rom_chan),
        .cmd_out(rom_cmd),
        .data_out(rom_data)
    );

    // Zero timeout selects the default limit
    assign limit = (timeout_in == 24'h000000) ? `TIMEOUT_DEFAULT : timeout_in;
    // Valid and busy are plain decodes of the state
    assign cmd_valid_out = (state_r == S_SEND);
    assign busy_out = (state_r == S_SEND) || (state_r == S_WAIT);
    // Only the application half is writable remotely
    assign flash_write_ok_out = (flash_addr_in >= `FLASH_APP_BASE) &&
                                (flash_addr_in <= flash_end_in);

    // ****************************************
    // Next state
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (start_in || reload_in) begin
                    state_nxt = S_SEND;
                end
            end
            S_SEND: begin
                if (cmd_ready_in) begin
                    state_nxt = S_WAIT;
                end
            end
            S_WAIT: begin
                // Next command only after this reply
                if (reply_valid_in) begin
                    if (reply_flag_in != 8'h00) begin
                        state_nxt = S_STOP;
                    end else if (step_r == LAST_STEP) begin
                        state_nxt = S_IDLE;
                    end else begin
                        state_nxt = S_SEND;
                    end
                end else if (wait_cnt_r >= limit) begin
                    state_nxt = S_STOP;
                end
            end
            S_STOP: begin
                if (start_in || reload_in) begin
                    state_nxt = S_SEND;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // ****************************************
    // Step to be sent next
    // ****************************************
    // The table is read with the coming step, so its word is ready as SEND is entered
    always @* begin
        step_nxt = step_r;
        if ((state_r == S_IDLE || state_r == S_STOP) && (start_in || reload_in)) begin
            // Reload repeats only config request and release
            step_nxt = start_in ? 4'h0 : 4'h7;
        end else if (state_r == S_WAIT && reply_valid_in && reply_flag_in == 8'h00 && step_r != LAST_STEP) begin
            // A good reply to any step but the last moves on by one
            step_nxt = step_r + 4'h1;
        end
    end

    // ****************************************
    // Command word and output shadow
    // ****************************************
    // Whole word latched once on entry to SEND, so it stands unchanged until taken
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            cmd_chan_out <= 8'h00;
            cmd_code_out <= 8'h00;
            cmd_data_out <= 32'h00000000;
            pin_shadow_out <= 32'h00000000;
        end else begin
            // Entry from IDLE, STOP or WAIT; the table already shows the coming step
            if (state_nxt == S_SEND && state_r != S_SEND) begin
                cmd_chan_out <= rom_chan;
                cmd_code_out <= rom_cmd;
                cmd_data_out <= rom_data;
            end
            // Shadow follows every output word that the encoder takes
            if (state_r == S_SEND && cmd_ready_in &&
                cmd_chan_out == `CH_PIN && cmd_code_out == `CMD_PIN_OUT_WR) begin
                pin_shadow_out <= cmd_data_out;
            end
        end
    end

    // ****************************************
    // Sequencing registers
    // ****************************************
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r <= S_IDLE;
            step_r <= 4'h0;
            wait_cnt_r <= 24'h000000;
            done_out <= 1'b0;
            error_out <= 1'b0;
            timeout_err_out <= 1'b0;
            err_flag_out <= 8'h00;
            err_step_out <= 4'h0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            if ((state_r == S_IDLE || state_r == S_STOP) && (start_in || reload_in)) begin
                // A new run clears the done and error flags of the last one; err_flag_out and err_step_out keep their values
                done_out <= 1'b0;
                error_out <= 1'b0;
                timeout_err_out <= 1'b0;
            end
            if (state_r == S_SEND) begin
                // Reply wait counter starts afresh for each command
                wait_cnt_r <= 24'h000000;
            end
            if (state_r == S_WAIT) begin
                wait_cnt_r <= wait_cnt_r + 24'h000001;
                if (reply_valid_in && reply_flag_in == 8'h00) begin
                    if (step_r == LAST_STEP) begin
                        done_out <= 1'b1;
                    end
                end else if (reply_valid_in) begin
                    error_out <= 1'b1;
                    err_flag_out <= reply_flag_in;
                    err_step_out <= step_r;
                end else if (wait_cnt_r >= limit) begin
                    error_out <= 1'b1;
                    timeout_err_out <= 1'b1;
                    err_step_out <= step_r;
                end
            end
        end
    end

endmodule

// >>> tb/bringup_checker.sv
// Port checker for the bring-up sequencer
`timescale 1ns/1ps
module bringup_checker (
    input wire core_clk_in, // Clock
    input wire rst_in, // Reset
    input wire [23:0] timeout_in, // Timeout
    input wire cmd_ready_in, // Ready
    input wire reply_valid_in, // Reply
    input wire [7:0] reply_flag_in, // Flag
    input wire [23:0] flash_addr_in, // Address
    input wire [23:0] flash_end_in, // End
    input wire cmd_valid_out, // Valid
    input wire [7:0] cmd_chan_out, // Channel
    input wire [7:0] cmd_code_out, // Code
    input wire [31:0] pin_shadow_out, // Shadow
    input wire [31:0] cmd_data_out, // Data
    input wire busy_out, // Busy
    input wire done_out, // Done
    input wire error_out, // Error
    input wire timeout_err_out, // Timeout
    input wire [7:0] err_flag_out, // Flag
    input wire flash_write_ok_out // Window
);
    default clocking dc @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reg [24:0] wait_r;
    wire acc = cmd_valid_out && cmd_ready_in;
    // Cycles spent waiting for a reply
    always @(posedge core_clk_in) begin
        wait_r <= (rst_in || !busy_out || cmd_valid_out) ? 25'h0 : wait_r + 25'h1;
    end
    // ****************
    // Port relations
    // ****************
    a_flash_window: assert property (flash_write_ok_out == (flash_addr_in >= 24'h800000 &&
        flash_addr_in <= flash_end_in)) else $error("flash window wrong");
    a_valid_stands: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out)
        else $error("command dropped");
    a_accept_waits: assert property (acc |=> !cmd_valid_out && busy_out)
        else $error("no wait after accept");
    a_flag_stops: assert property (busy_out && !cmd_valid_out && reply_valid_in && reply_flag_in != 8'h00
        |=> error_out && !busy_out && err_flag_out == $past(reply_flag_in)) else $error("bad flag not stopped");
    a_done_reply: assert property ($rose(done_out) |-> $past(reply_valid_in) && !busy_out)
        else $error("done without reply");
    a_pin_channel: assert property (acc ##1 cmd_code_out == 8'h10 |-> cmd_chan_out == 8'h02)
        else $error("output write on wrong channel");
    a_shadow_load: assert property (acc ##1 cmd_code_out == 8'h10 |-> pin_shadow_out == cmd_data_out)
        else $error("shadow not loaded");
    a_power_kept: assert property (pin_shadow_out != 32'h0 |-> (pin_shadow_out & 32'h08400200) == 32'h08400200)
        else $error("power bits dropped");
    a_wait_bound: assert property (timeout_in != 24'h0 |-> wait_r <= {1'b0, timeout_in} + 25'h3)
        else $error("reply wait overran");
    a_timeout_stop: assert property ($rose(timeout_err_out) |-> error_out && !busy_out)
        else $error("timeout not stopped");
    c_done: cover property ($rose(done_out));
    c_error: cover property ($rose(error_out) && !timeout_err_out);
    c_timeout: cover property ($rose(timeout_err_out));
endmodule

// >>> tb/adapter_model.sv
// Far-side frame encoder and adapter reply model
`timescale 1ns/1ps
module adapter_model (
    input wire clk_in, // Clock
    input wire rst_in, // Reset
    input wire cmd_valid_in, // Command valid
    input wire [7:0] chan_in, // Channel
    input wire [7:0] code_in, // Code
    input wire [31:0] data_in, // Data
    input wire [3:0] bad_step_in, // Step answered with a bad flag
    input wire mute_in, // Withhold replies
    output reg ready_out, // Accept
    output reg reply_valid_out, // Reply pulse
    output reg [7:0] reply_flag_out // Reply flag
);
    reg [47:0] got_q[$];
    integer seed = 32'h83afa405;
    // Ready is offered at random, also in the first cycle of valid; a command is taken
    // at the edge where valid meets ready and is answered by one reply pulse later on
    initial begin
        ready_out = 1'b0;
        reply_valid_out = 1'b0;
        reply_flag_out = 8'hff;
        forever begin
            @(posedge clk_in);
            if (cmd_valid_in && ready_out && !rst_in) begin
                // Record the word as it stands at the accepting edge
                got_q.push_back({chan_in, code_in, data_in});
                #1 ready_out = 1'b0;
                if (!mute_in) begin
                    repeat (1 + {$random(seed)} % 3) @(posedge clk_in);
                    #1 reply_valid_out = 1'b1;
                    reply_flag_out = (got_q.size() - 1 == bad_step_in) ? 8'h5a : 8'h00;
                    @(posedge clk_in);
                    #1 reply_valid_out = 1'b0;
                    reply_flag_out = ~reply_flag_out;
                    ready_out = ({$random(seed)} % 3) != 0;
                end
            end else begin
                #1 ready_out = ({$random(seed)} % 3) != 0;
            end
        end
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the bring-up sequencer
`timescale 1ns/1ps
module tb;
    reg core_clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, reload_in = 1'b0, mute = 1'b0;
    reg [23:0] timeout_in = 24'h14, flash_addr_in = 24'h0, flash_end_in = 24'hd7370d;
    reg [3:0] bad_step = 4'hf;
    wire cmd_ready_in, reply_valid_in, cmd_valid_out, busy_out, done_out, error_out, timeout_err_out, flash_write_ok_out;
    wire [7:0] reply_flag_in, cmd_chan_out, cmd_code_out, err_flag_out;
    wire [31:0] cmd_data_out, pin_shadow_out;
    wire [3:0] err_step_out;
    integer seed = 32'h83afa405, error_cnt = 0, checks = 0, cyc = 0, i, k;
    always #2 core_clk_in = ~core_clk_in;
    board_bringup_command_sequencer u_board_bringup_command_sequencer (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .start_in(start_in), .reload_in(reload_in), .timeout_in(timeout_in), .cmd_ready_in(cmd_ready_in),
        .reply_valid_in(reply_valid_in), .reply_flag_in(reply_flag_in), .flash_addr_in(flash_addr_in),
        .flash_end_in(flash_end_in), .cmd_valid_out(cmd_valid_out), .cmd_chan_out(cmd_chan_out),
        .cmd_code_out(cmd_code_out), .cmd_data_out(cmd_data_out), .pin_shadow_out(pin_shadow_out),
        .busy_out(busy_out), .done_out(done_out), .error_out(error_out), .timeout_err_out(timeout_err_out),
        .err_flag_out(err_flag_out), .err_step_out(err_step_out), .flash_write_ok_out(flash_write_ok_out));
    adapter_model u_adapter_model (.clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_out),
        .chan_in(cmd_chan_out), .code_in(cmd_code_out), .data_in(cmd_data_out), .bad_step_in(bad_step),
        .mute_in(mute), .ready_out(cmd_ready_in), .reply_valid_out(reply_valid_in), .reply_flag_out(reply_flag_in));
    // Expected channel, code and data of each step
    function [47:0] exp_cmd(input integer s);
        case (s)
            0: exp_cmd = 48'h00021c000000;
            1: exp_cmd = 48'h000400000000;
            2: exp_cmd = 48'h000610000000;
            3: exp_cmd = 48'h033088000000;
            4: exp_cmd = 48'h043088000000;
            5: exp_cmd = 48'h022008400638;
            6: exp_cmd = 48'h021008400200;
            7: exp_cmd = 48'h02108c600238;
            default: exp_cmd = 48'h021008400238;
        endcase
    endfunction
    task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Launch a run, poke a stray start while busy, wait for the end
    task run(input logic rel);
        begin
            u_adapter_model.got_q.delete();
            if (rel) reload_in = 1'b1;
            else start_in = 1'b1;
            @(posedge core_clk_in);
            #1 {start_in, reload_in} = 2'b00;
            repeat (2) @(posedge core_clk_in);
            #1 start_in = 1'b1;
            @(posedge core_clk_in);
            #1 start_in = 1'b0;
            for (i = 0; i < 2000 && busy_out === 1'b1; i = i + 1) begin
                @(posedge core_clk_in);
                #1;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Cycle ceiling against hangs
    always @(posedge core_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        run(0);
        chk("count", 9, u_adapter_model.got_q.size());
        for (k = 0; k < 9; k = k + 1) begin
            chk("cmd", exp_cmd(k), u_adapter_model.got_q[k]);
        end
        chk("shadow", 32'h08400238, pin_shadow_out);
        chk("done", 1, done_out);
        $display("test full done");
        run(1);
        chk("count", 2, u_adapter_model.got_q.size());
        for (k = 0; k < 2; k = k + 1) chk("cmd", exp_cmd(k + 7), u_adapter_model.got_q[k]);
        $display("test reload done");
        for (k = 0; k < 3; k = k + 1) begin
            bad_step = (k == 2) ? 4'h8 : 4'({$random(seed)} % 9);
            run(0);
            chk("error", 1, error_out);
            chk("step", bad_step, err_step_out);
            chk("flag", 8'h5a, err_flag_out);
            chk("count", bad_step + 1, u_adapter_model.got_q.size());
        end
        bad_step = 4'hf;
        $display("test flag done");
        mute = 1'b1;
        timeout_in = 24'h8 + 24'({$random(seed)} % 16);
        run(0);
        chk("timeout", 1, timeout_err_out);
        chk("step", 0, err_step_out);
        mute = 1'b0;
        rst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        chk("reset", 0, {error_out, busy_out, pin_shadow_out});
        $display("test timeout done");
        for (k = 0; k < 24; k = k + 1) begin
            @(posedge core_clk_in);
            #1 flash_addr_in = (k < 4) ? flash_end_in - 24'h1 + 24'(k == 1) : 24'($random(seed));
            if (k == 2) flash_addr_in = 24'h7fffff;
            if (k == 3) flash_addr_in = 24'h800000;
            #1 chk("window", flash_addr_in >= 24'h800000 && flash_addr_in <= flash_end_in, flash_write_ok_out);
        end
        $display("test flash done");
        give_verdict;
    end
endmodule
bind board_bringup_command_sequencer bringup_checker u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .timeout_in(timeout_in), .cmd_ready_in(cmd_ready_in), .reply_valid_in(reply_valid_in),
    .reply_flag_in(reply_flag_in), .flash_addr_in(flash_addr_in), .flash_end_in(flash_end_in),
    .cmd_valid_out(cmd_valid_out), .cmd_chan_out(cmd_chan_out), .cmd_code_out(cmd_code_out),
    .pin_shadow_out(pin_shadow_out), .cmd_data_out(cmd_data_out), .busy_out(busy_out), .done_out(done_out),
    .error_out(error_out), .timeout_err_out(timeout_err_out), .err_flag_out(err_flag_out),
    .flash_write_ok_out(flash_write_ok_out));
